// *** src/boag_top.v ***
// branch and operand address generator with general register banks
`include "boag_defs.vh"

// How it works
// - sequential fetch moves the program counter on by the instruction length.
// - relative branch adds sign-extended 8-bit displacement to next instruction address.
// - long call and branch load the 16-bit immediate into the counter.
// - short-form call reaches only 0800H to 0FFFH from its 11-bit field.
// - table call uses opcode bits 1 to 5 to pick a table entry.
// - call table sits at 40H to 7FH, each entry a full 16-bit target.
// - register branch copies the accumulator pair into the counter.
// - multiply takes A as multiplicand and writes 16-bit product to AX.
// - word divide reads dividend from AX and writes quotient back to AX.
// - decimal adjust and digit rotate work on A with no operand field.
// - 3-bit code picks an 8-bit register inside the flag-selected bank.
// - byte codes map X,A,C,B,E,D,L,H; pair codes map AX,BC,DE,HL.
// - direct addressing uses the 16-bit immediate unchanged as address.
// - short direct operand below 20H sets address bit 8, else clears it.
// - short direct FE20H-FEFFH is RAM, FF00H-FF1FH is special registers.
// - word short direct operands must be even.
// - sfr operand reaches FF00H-FFCFH and FFE0H-FFFFH only.
// - word sfr operand names only 16-bit capable registers at even addresses.
// - memory size register resets to CFH, software rewrites it.
module boag_top #(
  parameter [15:0] RESET_PC = 16'h0000,
  parameter [7:0] CPU_CLOCK_RESET = `BOAG_RST_CPU_CLOCK
) (
  // clock and reset
  input wire clk_in,
  input wire rst_in,
  // program counter requests
  input wire pc_req_in,
  input wire [2:0] pc_op_in,
  input wire [2:0] instr_len_in,
  input wire [7:0] disp_in,
  input wire [15:0] imm16_in,
  input wire [10:0] imm11_in,
  input wire [4:0] table_index_in,
  output reg [15:0] pc_out,
  output reg pc_busy_out,
  // branch table read
  output reg table_rd_out,
  output reg [15:0] table_addr_out,
  input wire table_valid_in,
  input wire [15:0] table_data_in,
  // operand address requests
  input wire opnd_req_in,
  input wire [2:0] opnd_mode_in,
  input wire [7:0] opnd8_in,
  output reg [15:0] ea_out,
  output reg ea_is_ram_out,
  output reg ea_is_sfr_out,
  output reg ea_fault_out,
  output reg ea_valid_out,
  // bank select flags
  input wire bank_select_low_in,
  input wire bank_select_high_in,
  // general register access
  input wire [2:0] reg_code_in,
  input wire [1:0] pair_code_in,
  input wire reg_wr_in,
  input wire pair_wr_in,
  input wire [15:0] reg_wdata_in,
  output reg [7:0] reg_rdata_out,
  output reg [15:0] pair_rdata_out,
  // implied operations
  input wire [1:0] imp_op_in,
  input wire [7:0] imp_opnd_in,
  input wire [7:0] imp_result_in,
  output reg [7:0] acc_out,
  output reg [15:0] acc_pair_out,
  // control register access
  input wire [15:0] data_addr_in,
  input wire data_wr_in,
  input wire data_rd_in,
  input wire [7:0] data_wdata_in,
  output reg [7:0] data_rdata_out,
  output reg data_hit_out,
  // control register contents
  output reg [7:0] memory_size_switch_out,
  output reg [7:0] watchdog_mode_control_out,
  output reg [7:0] osc_settle_time_select_out,
  output reg [7:0] cpu_clock_control_out
);

  localparam ST_IDLE = 1'b0;
  localparam ST_TABLE = 1'b1;

  reg state;
  reg [7:0] regs [0:31];
  wire [1:0] bank;
  wire [4:0] acc_idx;
  wire [4:0] x_idx;
  wire [15:0] cur_pair;
  wire [15:0] product;
  wire [15:0] quotient;
  wire [15:0] calc_pc;
  wire [15:0] calc_ea;
  wire calc_ram;
  wire calc_sfr;
  wire calc_fault;
  reg [2:0] next_op;
  wire pc_take;
  wire hit_mem_size;
  wire hit_wdt_mode;
  wire hit_osc_settle;
  wire hit_cpu_clock;

  // ----------------------------------------
  // bank and implied register indexes
  // ----------------------------------------
  assign bank = {bank_select_high_in, bank_select_low_in};
  assign acc_idx = {bank, `BOAG_CODE_A};
  assign x_idx = {bank, `BOAG_CODE_X};
  assign cur_pair = {regs[acc_idx], regs[x_idx]};

  // implied arithmetic on A and AX
  assign product = regs[acc_idx] * imp_opnd_in;
  assign quotient = (imp_opnd_in == 8'h00) ? `BOAG_DIV_ZERO_Q :
                    cur_pair / {8'h00, imp_opnd_in};

  // ----------------------------------------
  // general register banks, one entry each
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi = gi + 1) begin : g_reg
      wire in_bank;
      wire byte_hit;
      wire pair_hit;
      wire is_acc;
      wire is_x;
      assign in_bank = (gi[4:3] == bank);
      assign byte_hit = in_bank && (gi[2:0] == reg_code_in);
      assign pair_hit = in_bank && (gi[2:1] == pair_code_in);
      assign is_acc = in_bank && (gi[2:0] == `BOAG_CODE_A);
      assign is_x = in_bank && (gi[2:0] == `BOAG_CODE_X);
      // implied writes take precedence over explicit writes
      always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          regs[gi] <= 8'h00;
        end else if ((imp_op_in == `BOAG_IMP_MUL) && (is_acc || is_x)) begin
          regs[gi] <= is_acc ? product[15:8] : product[7:0];
        end else if ((imp_op_in == `BOAG_IMP_DIV) && (is_acc || is_x)) begin
          regs[gi] <= is_acc ? quotient[15:8] : quotient[7:0];
        end else if ((imp_op_in == `BOAG_IMP_ACC) && is_acc) begin
          regs[gi] <= imp_result_in;
        end else if (pair_wr_in && pair_hit) begin
          regs[gi] <= gi[0] ? reg_wdata_in[15:8] : reg_wdata_in[7:0];
        end else if (reg_wr_in && byte_hit) begin
          regs[gi] <= reg_wdata_in[7:0];
        end
      end
    end
  endgenerate

  // register read ports, registered
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
      pair_rdata_out <= 16'h0000;
      acc_out <= 8'h00;
      acc_pair_out <= 16'h0000;
    end else begin
      reg_rdata_out <= regs[{bank, reg_code_in}];
      pair_rdata_out <= {regs[{bank, pair_code_in, 1'b1}], regs[{bank, pair_code_in, 1'b0}]};
      acc_out <= regs[acc_idx];
      acc_pair_out <= cur_pair;
    end
  end

  // ----------------------------------------
  // program counter sequencing
  // ----------------------------------------
  assign pc_take = pc_req_in && (state == ST_IDLE);

  // table entries are read from program memory, so choose the data path
  always @* begin
    if (state == ST_TABLE) begin
      next_op = `BOAG_PC_TABLE;
    end else begin
      next_op = pc_op_in;
    end
  end

  boag_pc_calc u_pc_calc (
    .pc_in(pc_out),
    .len_in(instr_len_in),
    .op_in(next_op),
    .disp_in(disp_in),
    .imm16_in(imm16_in),
    .imm11_in(imm11_in),
    .table_data_in(table_data_in),
    .acc_pair_in(cur_pair),
    .next_pc_out(calc_pc)
  );

  // counter update and table fetch state machine
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= ST_IDLE;
      pc_out <= RESET_PC;
      pc_busy_out <= 1'b0;
      table_rd_out <= 1'b0;
      table_addr_out <= 16'h0000;
    end else begin
      table_rd_out <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (pc_take && (pc_op_in == `BOAG_PC_TABLE)) begin
            state <= ST_TABLE;
            pc_busy_out <= 1'b1;
            table_rd_out <= 1'b1;
            table_addr_out <= {`BOAG_TABLE_BASE_HI, table_index_in, 1'b0};
          end else if (pc_take) begin
            pc_out <= calc_pc;
          end
        end
        ST_TABLE: begin
          if (table_valid_in) begin
            pc_out <= calc_pc;
            state <= ST_IDLE;
            pc_busy_out <= 1'b0;
          end
        end
        default: begin
          state <= ST_IDLE;
          pc_busy_out <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // operand effective address
  // ----------------------------------------
  boag_opnd_addr u_opnd_addr (
    .mode_in(opnd_mode_in),
    .opnd8_in(opnd8_in),
    .imm16_in(imm16_in),
    .ea_out(calc_ea),
    .is_ram_out(calc_ram),
    .is_sfr_out(calc_sfr),
    .fault_out(calc_fault)
  );

  // results held until the next request
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ea_out <= 16'h0000;
      ea_is_ram_out <= 1'b0;
      ea_is_sfr_out <= 1'b0;
      ea_fault_out <= 1'b0;
      ea_valid_out <= 1'b0;
    end else begin
      ea_valid_out <= opnd_req_in;
      if (opnd_req_in) begin
        ea_out <= calc_ea;
        ea_is_ram_out <= calc_ram;
        ea_is_sfr_out <= calc_sfr;
        ea_fault_out <= calc_fault;
      end
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  assign hit_mem_size = (data_addr_in == `BOAG_ADDR_MEM_SIZE);
  assign hit_wdt_mode = (data_addr_in == `BOAG_ADDR_WDT_MODE);
  assign hit_osc_settle = (data_addr_in == `BOAG_ADDR_OSC_SETTLE);
  assign hit_cpu_clock = (data_addr_in == `BOAG_ADDR_CPU_CLOCK);

  // byte writes from the core
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      memory_size_switch_out <= `BOAG_RST_MEM_SIZE;
      watchdog_mode_control_out <= `BOAG_RST_WDT_MODE;
      osc_settle_time_select_out <= `BOAG_RST_OSC_SETTLE;
      cpu_clock_control_out <= CPU_CLOCK_RESET;
    end else if (data_wr_in) begin
      if (hit_mem_size) begin
        memory_size_switch_out <= data_wdata_in;
      end
      if (hit_wdt_mode) begin
        watchdog_mode_control_out <= data_wdata_in;
      end
      if (hit_osc_settle) begin
        osc_settle_time_select_out <= data_wdata_in;
      end
      if (hit_cpu_clock) begin
        cpu_clock_control_out <= data_wdata_in;
      end
    end
  end

  // read data one cycle after the read strobe
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      data_rdata_out <= 8'h00;
      data_hit_out <= 1'b0;
    end else if (data_rd_in) begin
      data_hit_out <= hit_mem_size | hit_wdt_mode | hit_osc_settle | hit_cpu_clock;
      if (hit_mem_size) begin
        data_rdata_out <= memory_size_switch_out;
      end else if (hit_wdt_mode) begin
        data_rdata_out <= watchdog_mode_control_out;
      end else if (hit_osc_settle) begin
        data_rdata_out <= osc_settle_time_select_out;
      end else if (hit_cpu_clock) begin
        data_rdata_out <= cpu_clock_control_out;
      end else begin
        data_rdata_out <= 8'h00; // unmapped reads as zero
      end
    end else begin
      data_hit_out <= 1'b0;
    end
  end

endmodule // boag_top

// *** shared/boag_defs.vh ***
// constants for the branch and operand address generator
`ifndef BOAG_DEFS_VH
`define BOAG_DEFS_VH

// ----------------------------------------
// program counter operations
// ----------------------------------------
`define BOAG_PC_SEQ 3'h0
`define BOAG_PC_REL 3'h1
`define BOAG_PC_LONG 3'h2
`define BOAG_PC_SHORT 3'h3
`define BOAG_PC_TABLE 3'h4
`define BOAG_PC_REG 3'h5

// ----------------------------------------
// branch targets and table
// ----------------------------------------
`define BOAG_SHORT_CALL_HI 5'h01
`define BOAG_TABLE_BASE_HI 10'h001
`define BOAG_SIGN_BIT 7

// ----------------------------------------
// operand addressing modes
// ----------------------------------------
`define BOAG_AM_DIRECT 3'h0
`define BOAG_AM_SADDR 3'h1
`define BOAG_AM_SADDRP 3'h2
`define BOAG_AM_SFR 3'h3
`define BOAG_AM_SFRP 3'h4

// ----------------------------------------
// fixed spaces
// ----------------------------------------
`define BOAG_RAM_PAGE 8'hFE
`define BOAG_SFR_PAGE 8'hFF
`define BOAG_SADDR_WRAP 8'h20
`define BOAG_SFR_GAP_LO 8'hD0
`define BOAG_SFR_GAP_HI 8'hDF
`define BOAG_SFRP_A 8'hE0
`define BOAG_SFRP_B 8'hE4
`define BOAG_SFRP_C 8'hE8

// ----------------------------------------
// general registers and implied operations
// ----------------------------------------
`define BOAG_CODE_X 3'h0
`define BOAG_CODE_A 3'h1
`define BOAG_IMP_NONE 2'h0
`define BOAG_IMP_MUL 2'h1
`define BOAG_IMP_DIV 2'h2
`define BOAG_IMP_ACC 2'h3
`define BOAG_DIV_ZERO_Q 16'hFFFF

// ----------------------------------------
// control registers
// ----------------------------------------
`define BOAG_ADDR_MEM_SIZE 16'hFFF0
`define BOAG_ADDR_WDT_MODE 16'hFFF9
`define BOAG_ADDR_OSC_SETTLE 16'hFFFA
`define BOAG_ADDR_CPU_CLOCK 16'hFFFB
`define BOAG_RST_MEM_SIZE 8'hCF
`define BOAG_RST_WDT_MODE 8'h00
`define BOAG_RST_OSC_SETTLE 8'h04
`define BOAG_RST_CPU_CLOCK 8'h00

`endif

// *** src/boag_pc_calc.v ***
// next program counter value for every branch and fetch kind
`include "boag_defs.vh"

module boag_pc_calc (
  // current state
  input wire [15:0] pc_in,
  input wire [2:0] len_in,
  // request
  input wire [2:0] op_in,
  input wire [7:0] disp_in,
  input wire [15:0] imm16_in,
  input wire [10:0] imm11_in,
  input wire [15:0] table_data_in,
  input wire [15:0] acc_pair_in,
  // result
  output reg [15:0] next_pc_out
);

  wire [15:0] seq_pc;
  wire [15:0] disp_ext;

  // ----------------------------------------
  // sequential and relative targets
  // ----------------------------------------
  assign seq_pc = pc_in + {13'h0000, len_in};
  assign disp_ext = {{8{disp_in[`BOAG_SIGN_BIT]}}, disp_in};

  // target select
  always @* begin
    case (op_in)
      `BOAG_PC_SEQ: next_pc_out = seq_pc;
      `BOAG_PC_REL: next_pc_out = seq_pc + disp_ext;
      `BOAG_PC_LONG: next_pc_out = imm16_in;
      `BOAG_PC_SHORT: next_pc_out = {`BOAG_SHORT_CALL_HI, imm11_in};
      `BOAG_PC_TABLE: next_pc_out = table_data_in;
      `BOAG_PC_REG: next_pc_out = acc_pair_in;
      default: next_pc_out = seq_pc;
    endcase
  end

endmodule // boag_pc_calc

// *** src/boag_opnd_addr.v ***
// effective operand address for direct, short direct and sfr forms
`include "boag_defs.vh"

module boag_opnd_addr (
  // request
  input wire [2:0] mode_in,
  input wire [7:0] opnd8_in,
  input wire [15:0] imm16_in,
  // result
  output reg [15:0] ea_out,
  output reg is_ram_out,
  output reg is_sfr_out,
  output reg fault_out
);

  wire short_hi;
  wire [7:0] short_page;
  wire sfr_gap;
  wire sfrp_ok;

  // ----------------------------------------
  // short direct page and sfr checks
  // ----------------------------------------
  assign short_hi = (opnd8_in < `BOAG_SADDR_WRAP);
  assign short_page = short_hi ? `BOAG_SFR_PAGE : `BOAG_RAM_PAGE;
  assign sfr_gap = (opnd8_in >= `BOAG_SFR_GAP_LO) && (opnd8_in <= `BOAG_SFR_GAP_HI);
  assign sfrp_ok = (opnd8_in == `BOAG_SFRP_A) || (opnd8_in == `BOAG_SFRP_B) ||
                   (opnd8_in == `BOAG_SFRP_C);

  // address form per mode
  always @* begin
    ea_out = imm16_in;
    is_ram_out = 1'b0;
    is_sfr_out = 1'b0;
    fault_out = 1'b0;
    case (mode_in)
      `BOAG_AM_DIRECT: begin
        ea_out = imm16_in;
      end
      `BOAG_AM_SADDR, `BOAG_AM_SADDRP: begin
        ea_out = {short_page, opnd8_in};
        is_ram_out = ~short_hi;
        is_sfr_out = short_hi;
        if (mode_in == `BOAG_AM_SADDRP) begin
          fault_out = opnd8_in[0];
        end
      end
      `BOAG_AM_SFR, `BOAG_AM_SFRP: begin
        ea_out = {`BOAG_SFR_PAGE, opnd8_in};
        is_sfr_out = ~sfr_gap;
        fault_out = sfr_gap;
        if (mode_in == `BOAG_AM_SFRP) begin
          fault_out = ~sfrp_ok;
        end
      end
      default: begin
        fault_out = 1'b1;
      end
    endcase
  end

endmodule // boag_opnd_addr

// *** bench/boag_monitor.sv ***
// assertion checker for the branch and operand address generator
`include "boag_defs.vh"
module boag_monitor (
  // clock, reset and program counter group
  input wire clk_in, input wire rst_in, input wire pc_req_in, input wire [2:0] pc_op_in,
  input wire [2:0] instr_len_in, input wire [7:0] disp_in, input wire [15:0] imm16_in,
  input wire [10:0] imm11_in, input wire [4:0] table_index_in, input wire [15:0] pc_out,
  input wire pc_busy_out, input wire table_rd_out, input wire [15:0] table_addr_out,
  input wire table_valid_in, input wire [15:0] table_data_in, input wire [15:0] acc_pair_out,
  // operand group
  input wire opnd_req_in, input wire [2:0] opnd_mode_in, input wire [7:0] opnd8_in,
  input wire [15:0] ea_out, input wire ea_is_ram_out, input wire ea_is_sfr_out,
  input wire ea_fault_out, input wire ea_valid_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // request qualifiers and operand classes
  wire go = pc_req_in && !pc_busy_out;
  wire [15:0] disp_sx = {{8{disp_in[7]}}, disp_in};
  wire sa = opnd_req_in && opnd_mode_in == `BOAG_AM_SADDR;
  wire sf = opnd_req_in && opnd_mode_in == `BOAG_AM_SFR;
  wire sa_low = opnd8_in < 8'h20;
  wire in_gap = opnd8_in >= 8'hD0 && opnd8_in <= 8'hDF;
  wire wide_ok = opnd8_in == 8'hE0 || opnd8_in == 8'hE4 || opnd8_in == 8'hE8;
  // ----------------------------------------
  // program counter
  // ----------------------------------------
  chk_rel_target: assert property (go && pc_op_in == `BOAG_PC_REL |=>
    pc_out == $past(pc_out) + $past(instr_len_in) + $past(disp_sx)) else $error("rel target");
  chk_short_call: assert property (go && pc_op_in == `BOAG_PC_SHORT |=>
    pc_out == 16'h0800 + $past(imm11_in)) else $error("short call target");
  chk_table_addr: assert property (go && pc_op_in == `BOAG_PC_TABLE |=>
    table_rd_out && pc_busy_out && table_addr_out == 16'h0040 + {$past(table_index_in), 1'b0})
    else $error("table address");
  chk_table_load: assert property (pc_busy_out && table_valid_in |=>
    !pc_busy_out && pc_out == $past(table_data_in)) else $error("table load");
  chk_reg_branch: assert property (go && pc_op_in == `BOAG_PC_REG |=>
    pc_out == acc_pair_out) else $error("register branch");
  // ----------------------------------------
  // operand addresses
  // ----------------------------------------
  chk_direct_addr: assert property (opnd_req_in && opnd_mode_in == `BOAG_AM_DIRECT |=>
    ea_valid_out && ea_out == $past(imm16_in)) else $error("direct address");
  chk_short_bit8: assert property (sa |=>
    ea_out == {7'h7F, $past(sa_low), $past(opnd8_in)}) else $error("short direct address");
  chk_short_space: assert property (sa |=>
    ea_is_sfr_out == $past(sa_low) && ea_is_ram_out == !$past(sa_low)) else $error("space");
  chk_short_even: assert property (opnd_req_in && opnd_mode_in == `BOAG_AM_SADDRP |=>
    ea_fault_out == |($past(opnd8_in) & 8'h01)) else $error("odd word short direct");
  chk_sfr_page: assert property (sf |=>
    ea_out == {8'hFF, $past(opnd8_in)}) else $error("sfr address");
  chk_sfr_gap: assert property (sf |=> ea_fault_out == $past(in_gap))
    else $error("sfr gap");
  chk_sfr_word: assert property (opnd_req_in && opnd_mode_in == `BOAG_AM_SFRP |=>
    ea_fault_out == !$past(wide_ok)) else $error("word sfr");
  // main scenarios
  cover property (pc_busy_out && table_valid_in);
  cover property (sa && sa_low);
  cover property (go && pc_op_in == `BOAG_PC_REL && disp_in[7]);
endmodule // boag_monitor

bind boag_top boag_monitor i_boag_monitor (
  .clk_in(clk_in), .rst_in(rst_in), .pc_req_in(pc_req_in), .pc_op_in(pc_op_in),
  .instr_len_in(instr_len_in), .disp_in(disp_in), .imm16_in(imm16_in), .imm11_in(imm11_in),
  .table_index_in(table_index_in), .pc_out(pc_out), .pc_busy_out(pc_busy_out),
  .table_rd_out(table_rd_out), .table_addr_out(table_addr_out),
  .table_valid_in(table_valid_in), .table_data_in(table_data_in),
  .acc_pair_out(acc_pair_out), .opnd_req_in(opnd_req_in), .opnd_mode_in(opnd_mode_in),
  .opnd8_in(opnd8_in), .ea_out(ea_out), .ea_is_ram_out(ea_is_ram_out),
  .ea_is_sfr_out(ea_is_sfr_out), .ea_fault_out(ea_fault_out), .ea_valid_out(ea_valid_out)
);

// *** bench/tb.sv ***
// self-checking bench for the branch and operand address generator
`include "boag_defs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in, rst_in, pc_req_in, table_valid_in, opnd_req_in, bank_select_low_in;
  logic bank_select_high_in, reg_wr_in, pair_wr_in, data_wr_in, data_rd_in, data_hit_out;
  logic [2:0] pc_op_in, instr_len_in, opnd_mode_in, reg_code_in;
  logic [7:0] disp_in, opnd8_in, imp_opnd_in, imp_result_in, data_wdata_in;
  logic [15:0] imm16_in, table_data_in, reg_wdata_in, data_addr_in;
  logic [10:0] imm11_in;
  logic [4:0] table_index_in;
  logic [1:0] pair_code_in, imp_op_in;
  logic [15:0] pc_out, table_addr_out, ea_out, pair_rdata_out, acc_pair_out;
  logic pc_busy_out, table_rd_out, ea_is_ram_out, ea_is_sfr_out, ea_fault_out, ea_valid_out;
  logic [7:0] reg_rdata_out, acc_out, data_rdata_out, memory_size_switch_out;
  logic [7:0] watchdog_mode_control_out, osc_settle_time_select_out, cpu_clock_control_out;
  int failures;
  int checked;

  boag_top i_boag_top (
    .clk_in(clk_in), .rst_in(rst_in), .pc_req_in(pc_req_in), .pc_op_in(pc_op_in),
    .instr_len_in(instr_len_in), .disp_in(disp_in), .imm16_in(imm16_in), .imm11_in(imm11_in),
    .table_index_in(table_index_in), .pc_out(pc_out), .pc_busy_out(pc_busy_out),
    .table_rd_out(table_rd_out), .table_addr_out(table_addr_out),
    .table_valid_in(table_valid_in), .table_data_in(table_data_in),
    .opnd_req_in(opnd_req_in), .opnd_mode_in(opnd_mode_in), .opnd8_in(opnd8_in),
    .ea_out(ea_out), .ea_is_ram_out(ea_is_ram_out), .ea_is_sfr_out(ea_is_sfr_out),
    .ea_fault_out(ea_fault_out), .ea_valid_out(ea_valid_out),
    .bank_select_low_in(bank_select_low_in), .bank_select_high_in(bank_select_high_in),
    .reg_code_in(reg_code_in), .pair_code_in(pair_code_in), .reg_wr_in(reg_wr_in),
    .pair_wr_in(pair_wr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .pair_rdata_out(pair_rdata_out), .imp_op_in(imp_op_in), .imp_opnd_in(imp_opnd_in),
    .imp_result_in(imp_result_in), .acc_out(acc_out), .acc_pair_out(acc_pair_out),
    .data_addr_in(data_addr_in), .data_wr_in(data_wr_in), .data_rd_in(data_rd_in),
    .data_wdata_in(data_wdata_in), .data_rdata_out(data_rdata_out),
    .data_hit_out(data_hit_out), .memory_size_switch_out(memory_size_switch_out),
    .watchdog_mode_control_out(watchdog_mode_control_out),
    .osc_settle_time_select_out(osc_settle_time_select_out),
    .cpu_clock_control_out(cpu_clock_control_out)
  );

  // 100 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // ----------------------------------------
  // shared helpers
  // ----------------------------------------
  task automatic tick;
    @(posedge clk_in);
    #1;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] d, input logic h);
    data_addr_in = a;
    data_rd_in = 1'b1;
    tick;
    data_rd_in = 1'b0;
    chk(data_rdata_out, d);
    chk(data_hit_out, h);
    tick;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    data_addr_in = a;
    data_wdata_in = d;
    data_wr_in = 1'b1;
    tick;
    data_wr_in = 1'b0;
  endtask

  task automatic pc_go(input logic [2:0] op);
    pc_op_in = op;
    pc_req_in = 1'b1;
    tick;
    pc_req_in = 1'b0;
    tick;
  endtask

  task automatic op_go(input logic [2:0] m, input logic [7:0] o, input logic [15:0] ea,
                       input logic [2:0] fl, input logic [2:0] mk);
    opnd_mode_in = m;
    opnd8_in = o;
    opnd_req_in = 1'b1;
    tick;
    opnd_req_in = 1'b0;
    chk(ea_valid_out, 1'b1);
    chk(ea_out, ea);
    chk({ea_is_ram_out, ea_is_sfr_out, ea_fault_out} & mk, fl);
    tick;
  endtask

  task automatic imp_go(input logic [1:0] op, input logic [7:0] o);
    imp_opnd_in = o;
    imp_op_in = op;
    tick;
    imp_op_in = `BOAG_IMP_NONE;
    tick;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_ctrl;
    logic [15:0] a [4] = '{16'hFFF0, 16'hFFF9, 16'hFFFA, 16'hFFFB};
    logic [7:0] r [4] = '{8'hCF, 8'h00, 8'h04, 8'h00};
    chk(memory_size_switch_out, 8'hCF);
    for (int i = 0; i < 4; i++) begin
      rd(a[i], r[i], 1'b1);
      wr(a[i], 8'hA0 | i[7:0]);
      rd(a[i], 8'hA0 | i[7:0], 1'b1);
    end
    wr(16'hFFF1, 8'h77);
    rd(16'hFFF1, 8'h00, 1'b0);
    chk(cpu_clock_control_out, 8'hA3);
    chk({watchdog_mode_control_out, osc_settle_time_select_out}, 16'hA1A2);
  endtask

  task automatic t_pc;
    instr_len_in = 3'h3;
    pc_go(`BOAG_PC_SEQ);
    chk(pc_out, 16'h0003);
    instr_len_in = 3'h2;
    disp_in = 8'h80;
    pc_go(`BOAG_PC_REL);
    chk(pc_out, 16'hFF85);
    instr_len_in = 3'h1;
    disp_in = 8'h7F;
    pc_go(`BOAG_PC_REL);
    chk(pc_out, 16'h0005);
    imm16_in = 16'h1234;
    pc_go(`BOAG_PC_LONG);
    chk(pc_out, 16'h1234);
    imm11_in = 11'h7FF;
    pc_go(`BOAG_PC_SHORT);
    chk(pc_out, 16'h0FFF);
  endtask

  task automatic t_table;
    int n;
    table_index_in = 5'h1F;
    pc_op_in = `BOAG_PC_TABLE;
    pc_req_in = 1'b1;
    tick;
    chk({table_rd_out, pc_busy_out}, 2'b11);
    chk(table_addr_out, 16'h007E);
    // a long branch while the table word is pending must be ignored
    imm16_in = 16'h5555;
    pc_op_in = `BOAG_PC_LONG;
    tick;
    pc_req_in = 1'b0;
    chk(table_rd_out, 1'b0);
    chk(pc_out, 16'h0FFF);
    table_data_in = 16'hBEEF;
    table_valid_in = 1'b1;
    tick;
    table_valid_in = 1'b0;
    for (n = 0; n < 8 && pc_busy_out !== 1'b0; n++) tick;
    if (n == 8) begin
      failures++;
      conclude;
    end
    chk(pc_out, 16'hBEEF);
  endtask

  task automatic t_opnd;
    imm16_in = 16'hFE00;
    op_go(`BOAG_AM_DIRECT, 8'h00, 16'hFE00, 3'b000, 3'b111);
    op_go(`BOAG_AM_SADDR, 8'h1F, 16'hFF1F, 3'b010, 3'b111);
    op_go(`BOAG_AM_SADDR, 8'h20, 16'hFE20, 3'b100, 3'b111);
    op_go(`BOAG_AM_SADDR, 8'hFF, 16'hFEFF, 3'b100, 3'b111);
    op_go(`BOAG_AM_SADDRP, 8'h31, 16'hFE31, 3'b001, 3'b001);
    op_go(`BOAG_AM_SADDRP, 8'h30, 16'hFE30, 3'b100, 3'b111);
    op_go(`BOAG_AM_SFR, 8'hCF, 16'hFFCF, 3'b010, 3'b111);
    op_go(`BOAG_AM_SFR, 8'hD0, 16'hFFD0, 3'b001, 3'b011);
    op_go(`BOAG_AM_SFR, 8'hE0, 16'hFFE0, 3'b010, 3'b111);
    op_go(`BOAG_AM_SFRP, 8'hE4, 16'hFFE4, 3'b010, 3'b111);
    op_go(`BOAG_AM_SFRP, 8'hE2, 16'hFFE2, 3'b001, 3'b001);
  endtask

  task automatic t_bank;
    logic [7:0] v;
    pair_wr_in = 1'b1;
    for (int b = 0; b < 4; b++) begin
      {bank_select_high_in, bank_select_low_in} = b[1:0];
      for (int p = 0; p < 4; p++) begin
        pair_code_in = p[1:0];
        reg_wdata_in = {8'h80 | 8'(b * 16 + p), 8'(b * 16 + p)};
        tick;
      end
    end
    pair_wr_in = 1'b0;
    for (int b = 0; b < 4; b++) begin
      {bank_select_high_in, bank_select_low_in} = b[1:0];
      for (int r = 0; r < 8; r++) begin
        reg_code_in = r[2:0];
        pair_code_in = r[2:1];
        v = 8'(b * 16 + r / 2);
        tick;
        chk(reg_rdata_out, v | {r[0], 7'h00});
        chk(pair_rdata_out, {8'h80 | v, v});
      end
    end
    // byte write into B of bank 0 shows as the high half of BC
    {bank_select_high_in, bank_select_low_in} = 2'b00;
    reg_code_in = 3'h3;
    pair_code_in = 2'h1;
    reg_wdata_in = 16'h00EE;
    reg_wr_in = 1'b1;
    tick;
    reg_wr_in = 1'b0;
    tick;
    chk(pair_rdata_out, 16'hEE01);
  endtask

  task automatic t_imp;
    pair_code_in = 2'h0;
    reg_wdata_in = 16'h1200;
    pair_wr_in = 1'b1;
    tick;
    pair_wr_in = 1'b0;
    imp_go(`BOAG_IMP_MUL, 8'h10);
    chk(acc_pair_out, 16'h0120);
    imp_go(`BOAG_IMP_DIV, 8'h07);
    chk(acc_pair_out, 16'h0029);
    imp_go(`BOAG_IMP_DIV, 8'h00);
    chk(acc_pair_out, 16'hFFFF);
    imp_result_in = 8'h5A;
    imp_go(`BOAG_IMP_ACC, 8'h00);
    chk(acc_pair_out, 16'h5AFF);
    chk(acc_out, 8'h5A);
    pc_go(`BOAG_PC_REG);
    chk(pc_out, 16'h5AFF);
  endtask

  // reset, then every scenario in turn
  initial begin
    failures = 0;
    checked = 0;
    {pc_req_in, table_valid_in, opnd_req_in, bank_select_low_in, bank_select_high_in} = '0;
    {reg_wr_in, pair_wr_in, data_wr_in, data_rd_in} = '0;
    {pc_op_in, instr_len_in, opnd_mode_in, reg_code_in, pair_code_in, imp_op_in} = '0;
    {disp_in, opnd8_in, imp_opnd_in, imp_result_in, data_wdata_in} = '0;
    {imm16_in, table_data_in, reg_wdata_in, data_addr_in, imm11_in, table_index_in} = '0;
    rst_in = 1'b1;
    repeat (12) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    t_ctrl;
    t_pc;
    t_table;
    t_opnd;
    t_bank;
    t_imp;
    conclude;
  end
endmodule // tb
